// >>> include/iemb_pkg.sv
// constants and register map of the interrupt enable mask bank
package iemb_pkg;
  // register indices; byte address is four times the index
  localparam logic [13:0] IDX_UNMASK_THERMAL_CLOCK = 14'h2011;
  localparam logic [13:0] IDX_UNMASK_POWER_SUPPLY_HEADROOM = 14'h2012;
  localparam logic [13:0] IDX_UNMASK_BROWNOUT_ENGINE = 14'h2013;
  localparam logic [13:0] IDX_FLAG_THERMAL_CLOCK = 14'h200c;
  localparam logic [13:0] IDX_FLAG_POWER_SUPPLY_HEADROOM = 14'h200d;
  localparam logic [13:0] IDX_FLAG_BROWNOUT_ENGINE = 14'h200e;
  localparam logic [13:0] IDX_CLEAR_THERMAL_CLOCK = 14'h2016;
  localparam logic [13:0] IDX_CLEAR_POWER_SUPPLY_HEADROOM = 14'h2017;
  localparam logic [13:0] IDX_CLEAR_BROWNOUT_ENGINE = 14'h2018;
  localparam logic [13:0] IDX_IRQ_CONTROL = 14'h2020;
  // implemented bits of each bank, bank n at bits 8n+7:8n
  localparam logic [7:0] IMPL_THERMAL_CLOCK = 8'hf7;
  localparam logic [7:0] IMPL_POWER_SUPPLY_HEADROOM = 8'h3f;
  localparam logic [7:0] IMPL_BROWNOUT_ENGINE = 8'h0f;
  localparam logic [7:0] UNMASK_RESET = 8'h00;
  localparam logic [7:0] IRQ_CONTROL_RESET = 8'h00;
  localparam int IRQ_ENABLE_BIT = 0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int SYNC_STAGES = 2;
endpackage : iemb_pkg

// >>> logic/iemb_mask_bank.sv
// interrupt enable mask bank with flag latches and axi4-lite slave
`timescale 1ns/10ps
`default_nettype none
module iemb_mask_bank #(
  parameter int ADDR_W = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // raw events, same bit layout as the enable registers
  input wire logic [7:0] raw_thermal_clock,
  input wire logic [7:0] raw_power_supply_headroom,
  input wire logic [7:0] raw_brownout_engine,
  // latched flags and interrupt
  output logic [23:0] event_flags,
  output logic irq
);

  if (ADDR_W < 16 || ADDR_W > 32) begin : g_addr_check
    $error("iemb_mask_bank: ADDR_W must be 16 to 32");
  end

  localparam logic [23:0] IMPL = {iemb_pkg::IMPL_BROWNOUT_ENGINE,
    iemb_pkg::IMPL_POWER_SUPPLY_HEADROOM, iemb_pkg::IMPL_THERMAL_CLOCK};
  localparam logic [23:0] UNMASK_RST = {3{iemb_pkg::UNMASK_RESET}};

  // state
  logic [23:0] unmask_q;
  logic [23:0] unmask_d;
  logic [23:0] sync1_q;
  logic [23:0] sync2_q;
  logic [23:0] sync3_q;
  logic [23:0] state_q;
  logic [23:0] state_d;
  logic [23:0] flag_q;
  logic [23:0] flag_d;
  logic [7:0] irq_ctl_q;
  logic [7:0] irq_ctl_d;
  logic irq_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  // write channel: address and data are taken together
  wire logic wr_go;
  wire logic [13:0] wr_idx;
  wire logic [2:0] wr_unmask_sel;
  wire logic [2:0] wr_clear_sel;
  wire logic [2:0] wr_flag_sel;
  wire logic wr_ctl_sel;
  wire logic wr_hit;
  wire logic wr_byte0;
  wire logic [23:0] wr_byte24;
  wire logic [23:0] unmask_we;
  wire logic [23:0] clear_we;
  wire logic [23:0] clear_strobe;

  // the upper address bits must be zero for a hit
  wire logic wr_high_zero;
  wire logic rd_high_zero;
  if (ADDR_W > 16) begin : g_high
    assign wr_high_zero = s_axi_awaddr[ADDR_W-1:16] == '0;
    assign rd_high_zero = s_axi_araddr[ADDR_W-1:16] == '0;
  end else begin : g_nohigh
    assign wr_high_zero = 1'b1;
    assign rd_high_zero = 1'b1;
  end

  // holding ready low until both are present lets the master send
  // them in either order without a skid buffer
  assign wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign wr_idx = s_axi_awaddr[15:2];
  assign wr_byte0 = wr_go && s_axi_wstrb[0];

  assign wr_unmask_sel[0] = wr_high_zero &&
    wr_idx == iemb_pkg::IDX_UNMASK_THERMAL_CLOCK;
  assign wr_unmask_sel[1] = wr_high_zero &&
    wr_idx == iemb_pkg::IDX_UNMASK_POWER_SUPPLY_HEADROOM;
  assign wr_unmask_sel[2] = wr_high_zero &&
    wr_idx == iemb_pkg::IDX_UNMASK_BROWNOUT_ENGINE;
  assign wr_clear_sel[0] = wr_high_zero &&
    wr_idx == iemb_pkg::IDX_CLEAR_THERMAL_CLOCK;
  assign wr_clear_sel[1] = wr_high_zero &&
    wr_idx == iemb_pkg::IDX_CLEAR_POWER_SUPPLY_HEADROOM;
  assign wr_clear_sel[2] = wr_high_zero &&
    wr_idx == iemb_pkg::IDX_CLEAR_BROWNOUT_ENGINE;
  assign wr_flag_sel[0] = wr_high_zero &&
    wr_idx == iemb_pkg::IDX_FLAG_THERMAL_CLOCK;
  assign wr_flag_sel[1] = wr_high_zero &&
    wr_idx == iemb_pkg::IDX_FLAG_POWER_SUPPLY_HEADROOM;
  assign wr_flag_sel[2] = wr_high_zero &&
    wr_idx == iemb_pkg::IDX_FLAG_BROWNOUT_ENGINE;
  assign wr_ctl_sel = wr_high_zero && wr_idx == iemb_pkg::IDX_IRQ_CONTROL;
  // flag registers are read only: a write there is accepted and dropped
  assign wr_hit = |wr_unmask_sel || |wr_clear_sel || |wr_flag_sel ||
    wr_ctl_sel;

  assign wr_byte24 = {3{s_axi_wdata[7:0]}};
  assign unmask_we = {{8{wr_unmask_sel[2]}}, {8{wr_unmask_sel[1]}},
    {8{wr_unmask_sel[0]}}} & {24{wr_byte0}};
  assign clear_we = {{8{wr_clear_sel[2]}}, {8{wr_clear_sel[1]}},
    {8{wr_clear_sel[0]}}} & {24{wr_byte0}};

  // reserved positions never store a one
  assign unmask_d = (unmask_q & ~unmask_we) |
    (wr_byte24 & unmask_we & IMPL);
  // only ones written produce a clear; zeros leave the bit alone
  assign clear_strobe = wr_byte24 & clear_we & IMPL;
  assign irq_ctl_d = (wr_byte0 && wr_ctl_sel) ?
    (s_axi_wdata[7:0] & 8'h01) : irq_ctl_q;

  // event path: synchroniser, edge detector, sticky state, flag
  wire logic [23:0] raw_all;
  wire logic [23:0] rise;
  wire logic flag_rise_any;

  assign raw_all = {raw_brownout_engine, raw_power_supply_headroom,
    raw_thermal_clock};
  // third stage only feeds the edge detector, never sync1
  assign rise = sync2_q & ~sync3_q & IMPL;
  // an edge in the clear cycle survives: set wins over clear
  assign state_d = ((state_q & ~clear_strobe) | rise) & IMPL;
  // a masked source stays low but its edge is remembered, so a
  // later unmask shows an edge that came while it was masked
  assign flag_d = state_d & unmask_q;
  // the second and third banks follow the same per-bit law
  assign flag_rise_any = |(flag_d & ~flag_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
    end else begin
      sync1_q <= raw_all;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      unmask_q <= UNMASK_RST;
      state_q <= '0;
      flag_q <= '0;
      irq_ctl_q <= iemb_pkg::IRQ_CONTROL_RESET;
      irq_q <= 1'b0;
    end else begin
      unmask_q <= unmask_d;
      state_q <= state_d;
      flag_q <= flag_d;
      irq_ctl_q <= irq_ctl_d;
      // one-cycle pulse per cycle in which any flag goes low to high, so flags rising together give one pulse
      irq_q <= irq_ctl_q[iemb_pkg::IRQ_ENABLE_BIT] && flag_rise_any;
    end
  end

  assign event_flags = flag_q;
  assign irq = irq_q;

  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= iemb_pkg::RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_hit ? iemb_pkg::RESP_OKAY : iemb_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // read channel
  wire logic rd_go;
  wire logic [13:0] rd_idx;
  wire logic rd_hit;
  wire logic rd_clear_sel;

  assign rd_go = s_axi_arvalid && !rvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign rd_idx = s_axi_araddr[15:2];
  // clear registers are write only and read back as zero
  assign rd_clear_sel = rd_high_zero &&
    (rd_idx == iemb_pkg::IDX_CLEAR_THERMAL_CLOCK ||
     rd_idx == iemb_pkg::IDX_CLEAR_POWER_SUPPLY_HEADROOM ||
     rd_idx == iemb_pkg::IDX_CLEAR_BROWNOUT_ENGINE);

  always_comb begin
    rdata_d = 32'h0000_0000;
    if (!rd_high_zero) begin
      rdata_d = 32'h0000_0000;
    end else if (rd_idx == iemb_pkg::IDX_UNMASK_THERMAL_CLOCK) begin
      rdata_d = {24'h00_0000, unmask_q[7:0]};
    end else if (rd_idx == iemb_pkg::IDX_UNMASK_POWER_SUPPLY_HEADROOM) begin
      rdata_d = {24'h00_0000, unmask_q[15:8]};
    end else if (rd_idx == iemb_pkg::IDX_UNMASK_BROWNOUT_ENGINE) begin
      rdata_d = {24'h00_0000, unmask_q[23:16]};
    end else if (rd_idx == iemb_pkg::IDX_FLAG_THERMAL_CLOCK) begin
      rdata_d = {24'h00_0000, flag_q[7:0]};
    end else if (rd_idx == iemb_pkg::IDX_FLAG_POWER_SUPPLY_HEADROOM) begin
      rdata_d = {24'h00_0000, flag_q[15:8]};
    end else if (rd_idx == iemb_pkg::IDX_FLAG_BROWNOUT_ENGINE) begin
      rdata_d = {24'h00_0000, flag_q[23:16]};
    end else if (rd_idx == iemb_pkg::IDX_IRQ_CONTROL) begin
      rdata_d = {24'h00_0000, irq_ctl_q};
    end
  end

  assign rd_hit = rd_high_zero && (rd_clear_sel ||
    rd_idx == iemb_pkg::IDX_UNMASK_THERMAL_CLOCK ||
    rd_idx == iemb_pkg::IDX_UNMASK_POWER_SUPPLY_HEADROOM ||
    rd_idx == iemb_pkg::IDX_UNMASK_BROWNOUT_ENGINE ||
    rd_idx == iemb_pkg::IDX_FLAG_THERMAL_CLOCK ||
    rd_idx == iemb_pkg::IDX_FLAG_POWER_SUPPLY_HEADROOM ||
    rd_idx == iemb_pkg::IDX_FLAG_BROWNOUT_ENGINE ||
    rd_idx == iemb_pkg::IDX_IRQ_CONTROL);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rresp_q <= iemb_pkg::RESP_OKAY;
      rdata_q <= 32'h0000_0000;
    end else if (rd_go) begin
      rvalid_q <= 1'b1;
      rresp_q <= rd_hit ? iemb_pkg::RESP_OKAY : iemb_pkg::RESP_SLVERR;
      rdata_q <= rdata_d;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;

  // assertions
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // a flag can only be high where its enable was high one cycle before
  a_mask_holds_low: assert property (
    ##1 ((flag_q & ~$past(unmask_q)) == 24'h00_0000))
    else $error("flag high while its enable was low");

  // a raw rise on an unmasked source shows on its flag three edges on,
  // whatever a clear in the same cycle asks for
  a_raw_to_flag: assert property (
    (!raw_all[7] ##1 raw_all[7] ##2 unmask_q[7]) |=> flag_q[7])
    else $error("thermal warning 2 begin edge not latched");

  a_raw_bank1_flag: assert property (
    (!raw_all[13] ##1 raw_all[13] ##2 unmask_q[13]) |=> flag_q[13])
    else $error("power up complete edge not latched");

  a_raw_bank2_flag: assert property (
    (!raw_all[19] ##1 raw_all[19] ##2 unmask_q[19]) |=> flag_q[19])
    else $error("brownout level zero edge not latched");

  a_edge_sets_flag: assert property (
    |(rise & unmask_q) |=> ((($past(rise & unmask_q)) & ~flag_q)
      == 24'h00_0000))
    else $error("unmasked edge did not set its flag");

  a_clear_one_clears: assert property (
    |clear_strobe |=> ((($past(clear_strobe & ~rise)) & state_q)
      == 24'h00_0000))
    else $error("clear strobe left a state bit set");

  a_clear_zero_keeps: assert property (
    (wr_byte0 && |wr_clear_sel && s_axi_wdata[7:0] == 8'h00)
    |=> (state_q & $past(state_q)) == $past(state_q))
    else $error("writing zero to a clear register lost state");

  a_reserved_zero: assert property (
    ((unmask_q | state_q | flag_q) & ~IMPL) == 24'h00_0000)
    else $error("reserved bit position holds a one");

  a_unmask_readback: assert property (
    (wr_byte0 && wr_unmask_sel[1]) |=>
      unmask_q[15:8] == ($past(s_axi_wdata[7:0]) &
      iemb_pkg::IMPL_POWER_SUPPLY_HEADROOM))
    else $error("enable register did not keep the written value");

  a_irq_on_rise: assert property (
    (irq_ctl_q[0] && |(flag_d & ~flag_q)) |=> irq)
    else $error("flag rise with output enabled gave no interrupt");

  a_irq_needs_rise: assert property (
    irq |-> $past(irq_ctl_q[0]) && $past(|(flag_d & ~flag_q)))
    else $error("interrupt without an enabled flag rise");

  a_bvalid_holds: assert property (
    (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid &&
      $stable(s_axi_bresp))
    else $error("write response dropped before bready");

  a_rvalid_holds: assert property (
    (s_axi_rvalid && !s_axi_rready) |=> s_axi_rvalid &&
      $stable(s_axi_rdata))
    else $error("read data dropped before rready");

  a_unmask_bank0: assert property (
    (wr_byte0 && wr_unmask_sel[0]) |=>
      unmask_q[7:0] == ($past(s_axi_wdata[7:0]) &
      iemb_pkg::IMPL_THERMAL_CLOCK))
    else $error("first enable register did not keep the written value");

  a_clear_drops_flag: assert property (
    |clear_strobe |=> ((($past(clear_strobe & ~rise)) & flag_q)
      == 24'h00_0000))
    else $error("clear strobe left a flag set");

  a_flag_needs_state: assert property (
    (flag_q & ~state_q) == 24'h00_0000)
    else $error("flag high without its stored edge");

  a_irq_ctl_reserved: assert property (
    irq_ctl_q[7:1] == 7'h00)
    else $error("reserved interrupt control bit holds a one");

  // both channels are taken at one edge, never one alone
  a_ready_pair: assert property (
    s_axi_awready |-> s_axi_awvalid && s_axi_wvalid && s_axi_wready)
    else $error("write channel taken without its partner");

  a_clear_reads_zero: assert property (
    (rd_go && rd_clear_sel) |=> s_axi_rvalid && s_axi_rdata == 32'h0)
    else $error("write only clear register read back nonzero");

  a_rdata_upper_zero: assert property (
    s_axi_rdata[31:8] == 24'h00_0000)
    else $error("read data above bit 7 not zero");

  c_unmask_write: cover property (wr_byte0 && |wr_unmask_sel);
  c_masked_edge: cover property (|(rise & ~unmask_q));
  c_flag_latched: cover property (|(flag_d & ~flag_q));
  c_set_and_clear: cover property (|(rise & clear_strobe));
  c_irq_pulse: cover property (irq);

endmodule : iemb_mask_bank
`default_nettype wire

// >>> tb/iemb_host_model.sv
// host side model: axi4-lite master that reaches the enable bank
`timescale 1ns/10ps
`default_nettype none
module iemb_host_model (
  input wire logic aclk,
  output logic [15:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [15:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  initial begin
    {awaddr, awvalid, wdata, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end

  // clearing is done by writing ones to a clear register, zeros spare it
  task automatic wr(input logic [15:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge aclk); while (awready !== 1'b1 || wready !== 1'b1);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    while (bvalid !== 1'b1) @(posedge aclk);
    r = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [15:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge aclk);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd
endmodule : iemb_host_model
`default_nettype wire

// >>> tb/iemb_mask_bank_tb_top.sv
// self-checking bench for the interrupt enable mask bank
`timescale 1ns/10ps
`default_nettype none
module iemb_mask_bank_tb_top;
  localparam logic [23:0] IMPL = {iemb_pkg::IMPL_BROWNOUT_ENGINE,
    iemb_pkg::IMPL_POWER_SUPPLY_HEADROOM, iemb_pkg::IMPL_THERMAL_CLOCK};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [15:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, irq;
  logic [31:0] wdata, rdata, d, w;
  logic [1:0] bresp, rresp, resp;
  logic [7:0] raw_t = 8'h00, raw_p = 8'h00, raw_b = 8'h00;
  logic [23:0] event_flags, f;
  logic [23:0] pend = 24'h0, en = 24'h0;
  int n_mismatch = 0, cmp_count = 0, n_irq = 0, k0;

  initial forever #5 aclk = ~aclk;
  always @(posedge aclk) if (irq === 1'b1) n_irq <= n_irq + 1;

  iemb_mask_bank dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .raw_thermal_clock(raw_t),
    .raw_power_supply_headroom(raw_p), .raw_brownout_engine(raw_b),
    .event_flags(event_flags), .irq(irq));

  iemb_host_model h (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready));

  function automatic logic [15:0] ba(input logic [13:0] b, input int k);
    return {b + 14'(k), 2'b00};
  endfunction : ba

  // a flag shows only where its source is unmasked and has seen a rise
  function automatic logic [23:0] exp_flags(input logic [23:0] e,
                                            input logic [23:0] s);
    return e & s & IMPL;
  endfunction : exp_flags

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] s);
    cmp_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic finish_test;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test

  task automatic set_en(input logic [23:0] e);
    for (int k = 0; k < 3; k++) begin
      h.wr(ba(iemb_pkg::IDX_UNMASK_THERMAL_CLOCK, k), {24'h0, e[8*k +: 8]},
           resp);
    end
    en = e;
  endtask : set_en

  task automatic clr(input logic [23:0] c);
    for (int k = 0; k < 3; k++) begin
      h.wr(ba(iemb_pkg::IDX_CLEAR_THERMAL_CLOCK, k), {24'h0, c[8*k +: 8]},
           resp);
    end
    pend = pend & ~c;
  endtask : clr

  // raw level held well past the two-flop synchroniser, then dropped
  task automatic pulse(input logic [23:0] p);
    @(posedge aclk);
    {raw_b, raw_p, raw_t} <= p;
    repeat (6) @(posedge aclk);
    {raw_b, raw_p, raw_t} <= 24'h0;
    repeat (6) @(posedge aclk);
    pend = pend | p;
  endtask : pulse

  task automatic chk_flags;
    repeat (2) @(posedge aclk);
    f = exp_flags(en, pend);
    chk("bank0 flags", {24'h0, f[7:0]}, {24'h0, event_flags[7:0]});
    chk("bank1 flags", {24'h0, f[15:8]}, {24'h0, event_flags[15:8]});
    chk("bank2 flags", {24'h0, f[23:16]}, {24'h0, event_flags[23:16]});
  endtask : chk_flags

  initial begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    finish_test;
  end

  initial begin
    void'($urandom(96));
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      h.rd(ba(iemb_pkg::IDX_UNMASK_THERMAL_CLOCK, k), d, resp);
      chk("enable reset", {24'h0, iemb_pkg::UNMASK_RESET}, d);
    end
    repeat (9) begin
      k0 = $urandom_range(2);
      w = $urandom;
      h.wr(ba(iemb_pkg::IDX_UNMASK_THERMAL_CLOCK, k0), w, resp);
      h.rd(ba(iemb_pkg::IDX_UNMASK_THERMAL_CLOCK, k0), d, resp);
      chk("enable readback", {24'h0, w[7:0] & IMPL[8*k0 +: 8]}, d);
    end
    h.wr(16'h0004, 32'hffffffff, resp);
    chk("unmapped write", {30'h0, iemb_pkg::RESP_SLVERR}, {30'h0, resp});
    h.rd(16'h0004, d, resp);
    chk("unmapped read", {30'h0, iemb_pkg::RESP_SLVERR}, {30'h0, resp});
    set_en(24'h0);
    clr(24'hffffff);
    pulse(24'hffffff);
    chk("masked flags", 32'h0, {8'h0, event_flags});
    set_en(24'hffffff);
    chk_flags;
    h.rd(ba(iemb_pkg::IDX_UNMASK_BROWNOUT_ENGINE, 0), d, resp);
    chk("reserved bits", {24'h0, iemb_pkg::IMPL_BROWNOUT_ENGINE}, d);
    // flag registers are read only: a zero written there clears nothing
    h.wr(ba(iemb_pkg::IDX_FLAG_THERMAL_CLOCK, 0), 32'h0, resp);
    chk("flag write resp", {30'h0, iemb_pkg::RESP_OKAY}, {30'h0, resp});
    h.rd(ba(iemb_pkg::IDX_CLEAR_THERMAL_CLOCK, 1), d, resp);
    chk("clear readback", 32'h0, d);
    w = $urandom;
    clr(w[23:0]);
    chk_flags;
    clr(24'h0);
    chk_flags;
    repeat (8) begin
      clr(24'hffffff);
      w = $urandom;
      set_en(w[23:0]);
      w = $urandom;
      pulse(w[23:0]);
      chk_flags;
      h.rd(ba(iemb_pkg::IDX_FLAG_THERMAL_CLOCK, 0), d, resp);
      chk("flag register", {24'h0, f[7:0]}, d);
    end
    clr(24'hffffff);
    set_en(24'hffffff);
    h.wr(ba(iemb_pkg::IDX_IRQ_CONTROL, 0), 32'h1, resp);
    k0 = n_irq;
    pulse(24'h000080);
    chk("irq pulses", 32'h1, n_irq - k0);
    h.wr(ba(iemb_pkg::IDX_IRQ_CONTROL, 0), 32'h0, resp);
    k0 = n_irq;
    pulse(24'h082040);
    chk("irq pulses off", 32'h0, n_irq - k0);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    h.rd(ba(iemb_pkg::IDX_UNMASK_THERMAL_CLOCK, 0), d, resp);
    chk("enable after reset", 32'h0, d);
    chk("flags after reset", 32'h0, {8'h0, event_flags});
    finish_test;
  end
endmodule : iemb_mask_bank_tb_top
`default_nettype wire
